// >>> cit_consts.vh
// constants for the core interrupt and trap control block
`ifndef CIT_CONSTS_VH
`define CIT_CONSTS_VH

// register byte offsets
`define CIT_OFF_STATUS 8'h00
`define CIT_OFF_CORE 8'h04
`define CIT_OFF_IC1 8'h08
`define CIT_OFF_IC2 8'h0c
`define CIT_OFF_IC3 8'h10
`define CIT_OFF_IC4 8'h14
`define CIT_OFF_PVEC 8'h18
`define CIT_OFF_UFLAG 8'h1c
`define CIT_OFF_UEN 8'h20
`define CIT_OFF_PRIO_LO 8'h24
`define CIT_OFF_PRIO_HI 8'h28

// field positions
`define CIT_LVL_LSB 5
`define CIT_CORE_LAT 15
`define CIT_CORE_LVL_HI 3
`define CIT_IC1_NEST 15
`define CIT_IC1_OVF_A 14
`define CIT_IC1_OVF_B 13
`define CIT_IC1_CAT_A 12
`define CIT_IC1_CAT_B 11
`define CIT_IC1_OVF_A_EN 10
`define CIT_IC1_OVF_B_EN 9
`define CIT_IC1_CAT_EN 8
`define CIT_IC1_SHIFT 7
`define CIT_IC1_DIV0 6
`define CIT_IC1_MATH 4
`define CIT_IC1_ADDR 3
`define CIT_IC1_STACK 2
`define CIT_IC1_CLKF 1
`define CIT_IC2_GIE 15
`define CIT_IC2_HOLD 14
`define CIT_IC2_SOFT_TRAP_STATE 13
`define CIT_IC3_NVM 8
`define CIT_IC3_DMA 5
`define CIT_IC3_LOOP 4
`define CIT_IC3_PLL 0
`define CIT_IC4_SOFTWARE_HARD_TRAP_FLAG 0
`define CIT_PV_LIVE 13
`define CIT_PV_LVL_LSB 8

// implemented bit masks
`define CIT_IC1_MASK 16'hffde
`define CIT_IC2_WMASK 16'ha00f
`define CIT_IC3_MASK 16'h0131
`define CIT_IC4_MASK 16'h0001
`define CIT_PRIO_MASK 16'h7777
`define CIT_UBYTE_MASK 16'h00ff

// reset values
`define CIT_IC2_RESET 16'h8000

// vector numbers
`define CIT_VEC_CLKF 8'h00
`define CIT_VEC_ADDR 8'h01
`define CIT_VEC_HARD 8'h02
`define CIT_VEC_STACK 8'h03
`define CIT_VEC_MATH 8'h04
`define CIT_VEC_SOFT 8'h06
`define CIT_VEC_USER0 8'h08

// trap priority levels, plus top user and nesting-off levels
`define CIT_LVL_CLKF 4'hf
`define CIT_LVL_ADDR 4'he
`define CIT_LVL_HARD 4'hd
`define CIT_LVL_STACK 4'hc
`define CIT_LVL_MATH 4'hb
`define CIT_LVL_SOFT 4'h9
`define CIT_LVL_USER_TOP 3'h7
`define CIT_LVL_NEST_OFF 4'h7

`endif

// >>> cit_core_model.sv
// processor core model that acknowledges presented requests after a set wait
module cit_core_model (
    input wire hclk,
    input wire hresetn,
    input wire ack_en,
    input wire [3:0] ack_wait,
    input wire irq_request,
    output logic irq_acknowledge
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_ff;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_ff <= 4'h0;
            irq_acknowledge <= 1'h0;
        end else if (ack_en && irq_request && !irq_acknowledge) begin
            wait_ff <= wait_ff + 4'h1;
            irq_acknowledge <= wait_ff >= ack_wait;
        end else begin
            wait_ff <= 4'h0;
            irq_acknowledge <= 1'h0;
        end
    end
endmodule

// >>> cit_ext_edge.v
// synchroniser and polarity-selected edge detector for the external request pins
module cit_ext_edge (
    input wire hclk,
    input wire hresetn,
    input wire [3:0] pin,
    input wire [3:0] polarity,
    output wire [3:0] edge_hit
);

genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : gen_pin
        reg meta_ff;
        reg sync_ff;
        reg last_ff;
        reg hit_ff;
        always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                meta_ff <= 1'b0;
                sync_ff <= 1'b0;
                last_ff <= 1'b0;
                hit_ff <= 1'b0;
            end else begin
                meta_ff <= pin[g];
                sync_ff <= meta_ff;
                last_ff <= sync_ff;
                // negative edge when polarity is 1, positive edge when 0
                hit_ff <= polarity[g] ? (last_ff & ~sync_ff) : (~last_ff & sync_ff);
            end
        end
        assign edge_hit[g] = hit_ff;
    end
endgenerate

endmodule

// >>> cit_trap_ctrl.v
// interrupt and trap control and status with an ahb-lite register slave
`include "cit_consts.vh"
// What this block does
// - cpu level is the three-bit status field joined with the high level bit
// - level field 111 gives level 7 or 15 and blocks user interrupts
// - high level bit set means level above 7, only traps taken
// - nesting disable makes the three-bit level field read-only to software
// - nesting disable 1 stops nesting, 0 allows it, resets to 0
// - latency mode bit: 1 variable, 0 fixed, resets to 0
// - overflow trap enables arm accumulator a/b traps and set their flags
// - catastrophic enable arms both accumulators, separate flags for a and b
// - math trap sets math flag plus divide-zero or bad-shift flag
// - address, stack and clock failure traps set their status flags
// - global enable gates all interrupts, traps stay active when cleared
// - holdoff bit is set while an interrupt holdoff is in effect
// - soft trap state bit keeps raising the software hard trap while set
// - each external input: polarity 1 negative edge, 0 positive edge
// - soft trap flags for nvm, dma, loop stack and aux pll events
// - register four bit 0 flags a software-generated hard trap
// - live select shows live vector, else vector captured at acknowledge
// - new level field shows the 4-bit level, live or captured by the same select as the vector
// - vector codes: traps 0-4 and 6, user sources from 8
// - unimplemented bits read zero and ignore writes
// - request flags set by source, cleared only by software
// - each user source takes one of seven priority levels
module cit_trap_ctrl (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire acc_a_overflow,
    input wire acc_b_overflow,
    input wire acc_a_catastrophic,
    input wire acc_b_catastrophic,
    input wire bad_shift,
    input wire divide_zero,
    input wire address_error,
    input wire stack_error,
    input wire clock_failure,
    input wire nvm_address_error,
    input wire dma_address_error,
    input wire loop_stack_overflow,
    input wire aux_pll_unlock,
    input wire software_hard_trap,
    input wire holdoff_in_effect,
    input wire [3:0] ext_irq_pin,
    input wire [3:0] periph_irq,
    input wire irq_acknowledge,
    output wire irq_request,
    output wire [7:0] irq_vector,
    output wire [3:0] irq_level,
    output wire [3:0] cpu_level,
    output wire var_latency_mode
);

localparam NCAND = 14;

reg act_ff;
reg wr_ff;
reg [7:0] adr_ff;
reg [2:0] current_level_low_ff;
reg current_level_high_bit_ff;
reg var_lat_ff;
reg [15:0] ic1_ff;
reg [15:0] ic2_ff;
reg holdoff_ff;
reg [15:0] ic3_ff;
reg [15:0] ic4_ff;
reg vector_live_select_ff;
reg [7:0] uflag_ff;
reg [7:0] uen_ff;
reg [15:0] prio_lo_ff;
reg [15:0] prio_hi_ff;
reg pend_ff;
reg [7:0] pend_vec_ff;
reg [3:0] pend_lvl_ff;
reg [7:0] cap_vec_ff;
reg [3:0] cap_lvl_ff;

wire [3:0] ext_edge;
wire [15:0] wdata;
wire take;
wire ack;
wire [15:0] hw1;
wire [15:0] hw3;
wire [15:0] hw4;
wire [NCAND-1:0] cand_req;
wire [4*NCAND-1:0] cand_lvl;
wire [7:0] live_vec;
wire [3:0] live_lvl;

reg [15:0] nxt_ic1;
reg [15:0] nxt_ic2;
reg [15:0] nxt_ic3;
reg [15:0] nxt_ic4;
reg [7:0] nxt_uflag;
reg [2:0] nxt_level_low;
reg nxt_level_high;
reg [15:0] rd_mux;
reg best_ok;
reg [3:0] best_lvl;
reg [7:0] best_vec;
integer k;

// true in the data phase of a write to the given offset
function hit;
    input [7:0] off;
    input wr;
    input [7:0] adr;
    begin
        hit = wr && (adr == off);
    end
endfunction

// vector number of a candidate slot, slots 0-5 traps, 6-13 user sources
function [7:0] vec_of;
    input [3:0] slot;
    begin
        case (slot)
            4'd0: vec_of = `CIT_VEC_CLKF;
            4'd1: vec_of = `CIT_VEC_ADDR;
            4'd2: vec_of = `CIT_VEC_HARD;
            4'd3: vec_of = `CIT_VEC_STACK;
            4'd4: vec_of = `CIT_VEC_MATH;
            4'd5: vec_of = `CIT_VEC_SOFT;
            default: vec_of = `CIT_VEC_USER0 + {4'h0, slot} - 8'h06;
        endcase
    end
endfunction

cit_ext_edge u_ext_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(ext_irq_pin),
    .polarity(ic2_ff[3:0]),
    .edge_hit(ext_edge)
);

// bus slave: single-cycle address capture, zero wait states
assign take = hsel & htrans[1] & hready;
assign wdata = hwdata[15:0];
assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign hrdata = {16'h0000, rd_mux};

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        act_ff <= 1'b0;
        wr_ff <= 1'b0;
        adr_ff <= 8'h00;
    end else if (hready) begin
        act_ff <= take;
        wr_ff <= take & hwrite;
        adr_ff <= haddr[7:0];
    end
end

// hardware-set trap causes
assign hw1[15] = 1'b0;
assign hw1[`CIT_IC1_OVF_A] = acc_a_overflow & ic1_ff[`CIT_IC1_OVF_A_EN];
assign hw1[`CIT_IC1_OVF_B] = acc_b_overflow & ic1_ff[`CIT_IC1_OVF_B_EN];
assign hw1[`CIT_IC1_CAT_A] = acc_a_catastrophic & ic1_ff[`CIT_IC1_CAT_EN];
assign hw1[`CIT_IC1_CAT_B] = acc_b_catastrophic & ic1_ff[`CIT_IC1_CAT_EN];
assign hw1[10:8] = 3'b000;
assign hw1[`CIT_IC1_SHIFT] = bad_shift;
assign hw1[`CIT_IC1_DIV0] = divide_zero;
assign hw1[5] = 1'b0;
assign hw1[`CIT_IC1_MATH] = bad_shift | divide_zero;
assign hw1[`CIT_IC1_ADDR] = address_error;
assign hw1[`CIT_IC1_STACK] = stack_error;
assign hw1[`CIT_IC1_CLKF] = clock_failure;
assign hw1[0] = 1'b0;

assign hw3 = {7'h00, nvm_address_error, 2'b00, dma_address_error, loop_stack_overflow,
    3'b000, aux_pll_unlock};
// a held software trap state keeps raising the software hard trap
assign hw4 = {15'h0000, software_hard_trap | ic2_ff[`CIT_IC2_SOFT_TRAP_STATE]};

assign ack = irq_acknowledge & pend_ff;

always @* begin
    // hardware set wins over a software clearing write
    nxt_ic1 = (hw1 | (hit(`CIT_OFF_IC1, wr_ff, adr_ff) ? wdata : ic1_ff))
        & `CIT_IC1_MASK;
    nxt_ic2 = hit(`CIT_OFF_IC2, wr_ff, adr_ff) ? (wdata & `CIT_IC2_WMASK) : ic2_ff;
    nxt_ic3 = (hw3 | (hit(`CIT_OFF_IC3, wr_ff, adr_ff) ? wdata : ic3_ff))
        & `CIT_IC3_MASK;
    nxt_ic4 = (hw4 | (hit(`CIT_OFF_IC4, wr_ff, adr_ff) ? wdata : ic4_ff))
        & `CIT_IC4_MASK;
    nxt_uflag = {periph_irq, ext_edge}
        | (hit(`CIT_OFF_UFLAG, wr_ff, adr_ff) ? wdata[7:0] : uflag_ff);
    nxt_level_low = current_level_low_ff;
    nxt_level_high = current_level_high_bit_ff;
    if (hit(`CIT_OFF_STATUS, wr_ff, adr_ff) && !ic1_ff[`CIT_IC1_NEST]) begin
        nxt_level_low = wdata[`CIT_LVL_LSB+2:`CIT_LVL_LSB];
    end
    if (hit(`CIT_OFF_CORE, wr_ff, adr_ff) && !wdata[`CIT_CORE_LVL_HI]) begin
        nxt_level_high = 1'b0;
    end
    if (ack) begin
        // with nesting off a user request parks the core at level 7
        if (pend_vec_ff >= `CIT_VEC_USER0 && ic1_ff[`CIT_IC1_NEST]) begin
            {nxt_level_high, nxt_level_low} = `CIT_LVL_NEST_OFF;
        end else begin
            {nxt_level_high, nxt_level_low} = pend_lvl_ff;
        end
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        current_level_low_ff <= 3'b000;
        current_level_high_bit_ff <= 1'b0;
        var_lat_ff <= 1'b0;
        ic1_ff <= 16'h0000;
        ic2_ff <= `CIT_IC2_RESET;
        holdoff_ff <= 1'b0;
        ic3_ff <= 16'h0000;
        ic4_ff <= 16'h0000;
        vector_live_select_ff <= 1'b0;
        uflag_ff <= 8'h00;
        uen_ff <= 8'h00;
        prio_lo_ff <= 16'h0000;
        prio_hi_ff <= 16'h0000;
    end else begin
        current_level_low_ff <= nxt_level_low;
        current_level_high_bit_ff <= nxt_level_high;
        if (hit(`CIT_OFF_CORE, wr_ff, adr_ff)) begin
            var_lat_ff <= wdata[`CIT_CORE_LAT];
        end
        ic1_ff <= nxt_ic1;
        ic2_ff <= nxt_ic2;
        holdoff_ff <= holdoff_in_effect;
        ic3_ff <= nxt_ic3;
        ic4_ff <= nxt_ic4;
        if (hit(`CIT_OFF_PVEC, wr_ff, adr_ff)) begin
            vector_live_select_ff <= wdata[`CIT_PV_LIVE];
        end
        uflag_ff <= nxt_uflag;
        if (hit(`CIT_OFF_UEN, wr_ff, adr_ff)) begin
            uen_ff <= wdata[7:0];
        end
        if (hit(`CIT_OFF_PRIO_LO, wr_ff, adr_ff)) begin
            prio_lo_ff <= wdata & `CIT_PRIO_MASK;
        end
        if (hit(`CIT_OFF_PRIO_HI, wr_ff, adr_ff)) begin
            prio_hi_ff <= wdata & `CIT_PRIO_MASK;
        end
    end
end

assign cpu_level = {current_level_high_bit_ff, current_level_low_ff};
assign var_latency_mode = var_lat_ff;

// trap candidates, active whatever the global enable says
assign cand_req[0] = ic1_ff[`CIT_IC1_CLKF];
assign cand_req[1] = ic1_ff[`CIT_IC1_ADDR];
assign cand_req[2] = ic4_ff[`CIT_IC4_SOFTWARE_HARD_TRAP_FLAG];
assign cand_req[3] = ic1_ff[`CIT_IC1_STACK];
assign cand_req[4] = |{ic1_ff[14:11], ic1_ff[`CIT_IC1_MATH]};
assign cand_req[5] = |ic3_ff;
assign cand_lvl[23:0] = {`CIT_LVL_SOFT, `CIT_LVL_MATH, `CIT_LVL_STACK,
    `CIT_LVL_HARD, `CIT_LVL_ADDR, `CIT_LVL_CLKF};

// user candidates, gated by flag, enable, global enable and holdoff
genvar g;
generate
    for (g = 0; g < 8; g = g + 1) begin : gen_user
        wire [2:0] prio;
        if (g < 4) begin : lo
            assign prio = prio_lo_ff[4*g+2:4*g];
        end else begin : hi
            assign prio = prio_hi_ff[4*(g-4)+2:4*(g-4)];
        end
        assign cand_lvl[4*(g+6)+3:4*(g+6)] = {1'b0, prio};
        assign cand_req[g+6] = uflag_ff[g] & uen_ff[g] & ic2_ff[`CIT_IC2_GIE]
            & (prio != 3'b000) & ~(holdoff_ff & (prio != `CIT_LVL_USER_TOP));
    end
endgenerate

// highest level above the cpu level; scanning down keeps the lowest vector on ties
always @* begin
    best_ok = 1'b0;
    best_lvl = 4'h0;
    best_vec = 8'h00;
    for (k = NCAND - 1; k >= 0; k = k - 1) begin
        if (cand_req[k] && (cand_lvl[4*k+:4] > cpu_level)
            && (!best_ok || cand_lvl[4*k+:4] >= best_lvl)) begin
            best_ok = 1'b1;
            best_lvl = cand_lvl[4*k+:4];
            best_vec = vec_of(k[3:0]);
        end
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        pend_ff <= 1'b0;
        pend_vec_ff <= 8'h00;
        pend_lvl_ff <= 4'h0;
        cap_vec_ff <= 8'h00;
        cap_lvl_ff <= 4'h0;
    end else begin
        // the request drops at acknowledge and is re-judged at the new level
        pend_ff <= best_ok & ~ack;
        pend_vec_ff <= best_vec;
        pend_lvl_ff <= best_lvl;
        if (ack) begin
            cap_vec_ff <= pend_vec_ff;
            cap_lvl_ff <= pend_lvl_ff;
        end
    end
end

assign irq_request = pend_ff;
assign irq_vector = pend_vec_ff;
assign irq_level = pend_lvl_ff;
assign live_vec = vector_live_select_ff ? pend_vec_ff : cap_vec_ff;
assign live_lvl = vector_live_select_ff ? pend_lvl_ff : cap_lvl_ff;

// read data for the data phase, unmapped offsets read zero
always @* begin
    rd_mux = 16'h0000;
    if (act_ff && !wr_ff) begin
        case (adr_ff)
            `CIT_OFF_STATUS: rd_mux = {8'h00, current_level_low_ff, 5'h00};
            `CIT_OFF_CORE: rd_mux = {var_lat_ff, 11'h000, current_level_high_bit_ff, 3'b000};
            `CIT_OFF_IC1: rd_mux = ic1_ff;
            `CIT_OFF_IC2: rd_mux = ic2_ff | {1'b0, holdoff_ff, 14'h0000};
            `CIT_OFF_IC3: rd_mux = ic3_ff;
            `CIT_OFF_IC4: rd_mux = ic4_ff;
            `CIT_OFF_PVEC: rd_mux = {2'b00, vector_live_select_ff, 1'b0, live_lvl, live_vec};
            `CIT_OFF_UFLAG: rd_mux = {8'h00, uflag_ff};
            `CIT_OFF_UEN: rd_mux = {8'h00, uen_ff};
            `CIT_OFF_PRIO_LO: rd_mux = prio_lo_ff;
            `CIT_OFF_PRIO_HI: rd_mux = prio_hi_ff;
            default: rd_mux = 16'h0000;
        endcase
    end
end

endmodule

// >>> cit_trap_ctrl_asserts.sv
// assertion checker for the interrupt and trap control block
`include "cit_consts.vh"
module cit_trap_ctrl_asserts (
    input wire hclk,
    input wire hresetn,
    input wire [31:0] hrdata,
    input wire holdoff_in_effect,
    input wire irq_acknowledge,
    input wire irq_request,
    input wire [7:0] irq_vector,
    input wire [3:0] irq_level,
    input wire [3:0] cpu_level
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    wire user_req = irq_request && irq_vector >= `CIT_VEC_USER0;
    wire [3:0] trap_lvl = irq_vector == `CIT_VEC_CLKF ? `CIT_LVL_CLKF :
        irq_vector == `CIT_VEC_ADDR ? `CIT_LVL_ADDR :
        irq_vector == `CIT_VEC_HARD ? `CIT_LVL_HARD :
        irq_vector == `CIT_VEC_STACK ? `CIT_LVL_STACK :
        irq_vector == `CIT_VEC_MATH ? `CIT_LVL_MATH : `CIT_LVL_SOFT;
    a_above_cpu_level: assert property (irq_request && $stable(cpu_level)
        |-> irq_level > cpu_level)
        else $error("request presented at or below cpu level");
    a_low_field_full: assert property (irq_request && $stable(cpu_level)
        && cpu_level[2:0] == 3'h7 |-> irq_vector < `CIT_VEC_USER0)
        else $error("user request at level field seven");
    a_high_bit_traps: assert property (irq_request && $stable(cpu_level)
        && cpu_level[3] |-> irq_vector < `CIT_VEC_USER0)
        else $error("user request above level seven");
    a_ack_takes_level: assert property (irq_acknowledge && irq_request && !user_req
        |=> cpu_level == $past(irq_level))
        else $error("cpu level not taken from acknowledged trap");
    a_ack_drops_req: assert property (irq_acknowledge && irq_request |=> !irq_request)
        else $error("request stays after acknowledge");
    a_vector_legal: assert property (irq_request
        |-> !(irq_vector inside {8'h05, 8'h07, 8'hff}))
        else $error("reserved vector presented");
    a_trap_level_map: assert property (irq_request && !user_req |-> irq_level == trap_lvl)
        else $error("trap level does not match vector");
    a_user_level_range: assert property (user_req |-> irq_level inside {[4'h1:4'h7]})
        else $error("user level outside one to seven");
    a_upper_zero: assert property (hrdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_holdoff_blocks: assert property (user_req && $past(holdoff_in_effect)
        && $past(holdoff_in_effect, 2) |-> irq_level == 4'h7)
        else $error("user request below seven during holdoff");
    c_user_ack: cover property (irq_acknowledge && user_req);
    c_trap_ack: cover property (irq_acknowledge && irq_request && !user_req);
    c_high_level_trap: cover property (irq_request && cpu_level[3]);
endmodule
bind cit_trap_ctrl cit_trap_ctrl_asserts cit_trap_ctrl_asserts_inst (.hclk, .hresetn, .hrdata,
    .holdoff_in_effect, .irq_acknowledge, .irq_request, .irq_vector, .irq_level, .cpu_level);

// >>> cit_trap_ctrl_tb.sv
// self-checking testbench for the interrupt and trap control block
module cit_trap_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic holdoff_in_effect = 1'h0;
    logic ack_en = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [13:0] ev = 14'h0;
    logic [3:0] ext_irq_pin = 4'h0;
    logic [3:0] periph_irq = 4'h0;
    logic [3:0] ack_wait = 4'h0;
    wire [31:0] hrdata;
    wire [7:0] irq_vector;
    wire [3:0] irq_level, cpu_level;
    wire hreadyout, hresp, irq_acknowledge, irq_request, var_latency_mode;
    int n_mismatch = 0;
    int check_count = 0;
    localparam logic [15:0] trap_exp [14] = '{16'h4700, 16'h2700, 16'h1700, 16'h0f00, 16'h0790,
        16'h0750, 16'h0708, 16'h0704, 16'h0702, 16'h0100, 16'h0020, 16'h0010, 16'h0001, 16'h0001};
    localparam logic [31:0] trap_req [14] = '{32'h1b04, 32'h1b04, 32'h1b04, 32'h1b04, 32'h1b04,
        32'h1b04, 32'h1e01, 32'h1c03, 32'h1f00, 32'h1906, 32'h1906, 32'h1906, 32'h1906, 32'h1d02};
    cit_trap_ctrl cit_trap_ctrl_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .acc_a_overflow(ev[0]), .acc_b_overflow(ev[1]), .acc_a_catastrophic(ev[2]),
        .acc_b_catastrophic(ev[3]), .bad_shift(ev[4]), .divide_zero(ev[5]),
        .address_error(ev[6]), .stack_error(ev[7]), .clock_failure(ev[8]),
        .nvm_address_error(ev[9]), .dma_address_error(ev[10]), .loop_stack_overflow(ev[11]),
        .aux_pll_unlock(ev[12]), .software_hard_trap(ev[13]), .holdoff_in_effect,
        .ext_irq_pin, .periph_irq, .irq_acknowledge, .irq_request, .irq_vector, .irq_level,
        .cpu_level, .var_latency_mode);
    cit_core_model cit_core_model_inst (.hclk, .hresetn, .ack_en, .ack_wait, .irq_request,
        .irq_acknowledge);
    initial begin
        forever #25 hclk = ~hclk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        r = hrdata;
        chk({30'h0, hresp, hreadyout}, 32'h1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] r;
        bus(a, 1'h1, {16'h0, d}, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        logic [31:0] r;
        bus(a, 1'h0, 32'h0, r);
        chk(r, {16'h0, e});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    task automatic pulse(input int i);
        @(posedge hclk);
        ev[i] <= 1'h1;
        @(posedge hclk);
        ev[i] <= 1'h0;
    endtask
    task automatic core(input logic en, input logic [3:0] w);
        @(posedge hclk);
        ack_en <= en;
        ack_wait <= w;
    endtask
    task automatic t_regs;
        rd(8'h0c, 16'h8000);
        rd(8'h08, 16'h0000);
        rd(8'h04, 16'h0000);
        rd(8'h18, 16'h0000);
        wr(8'h04, 16'hffff);
        rd(8'h04, 16'h8000);
        chk({31'h0, var_latency_mode}, 32'h1);
        wr(8'h04, 16'h0000);
        wr(8'h10, 16'hffff);
        rd(8'h10, 16'h0131);
        wr(8'h10, 16'h0000);
        wr(8'h0c, 16'hffff);
        rd(8'h0c, 16'ha00f);
        wr(8'h0c, 16'h8000);
        rd(8'h14, 16'h0001);
        wr(8'h14, 16'hffff);
        rd(8'h14, 16'h0001);
        wr(8'h14, 16'h0000);
        wr(8'h3c, 16'hffff);
        rd(8'h3c, 16'h0000);
        wr(8'h08, 16'hffff);
        rd(8'h08, 16'hffde);
        wr(8'h08, 16'h0000);
        $display("register test done");
    endtask
    task automatic t_traps;
        logic [7:0] a;
        for (int i = 0; i < 4; i++) pulse(i);
        rd(8'h08, 16'h0000);
        wr(8'h08, 16'h0700);
        for (int i = 0; i < 14; i++) begin
            a = i < 9 ? 8'h08 : i < 13 ? 8'h10 : 8'h14;
            pulse(i);
            cyc(1);
            chk({19'h0, irq_request, irq_level, irq_vector}, trap_req[i]);
            rd(a, trap_exp[i]);
            wr(a, i < 9 ? 16'h0700 : 16'h0000);
        end
        wr(8'h08, 16'h0000);
        $display("trap test done");
    endtask
    task automatic t_user;
        logic [31:0] r;
        wr(8'h20, 16'h00ff);
        wr(8'h28, 16'h0033);
        @(posedge hclk);
        periph_irq <= 4'h3;
        @(posedge hclk);
        periph_irq <= 4'h0;
        cyc(1);
        chk({19'h0, irq_request, irq_level, irq_vector}, 32'h130c);
        core(1'h1, 4'h3);
        cyc(10);
        chk({28'h0, cpu_level}, 32'h3);
        chk({31'h0, irq_request}, 32'h0);
        core(1'h0, 4'h0);
        rd(8'h18, 16'h030c);
        wr(8'h18, 16'h2000);
        wr(8'h00, 16'h0000);
        cyc(2);
        bus(8'h18, 1'h0, 32'h0, r);
        chk({24'h0, r[7:0]}, 32'h0c);
        wr(8'h18, 16'h0000);
        wr(8'h0c, 16'h0000);
        cyc(2);
        chk({31'h0, irq_request}, 32'h0);
        wr(8'h0c, 16'h8000);
        @(posedge hclk);
        holdoff_in_effect <= 1'h1;
        cyc(3);
        chk({31'h0, irq_request}, 32'h0);
        rd(8'h0c, 16'hc000);
        @(posedge hclk);
        holdoff_in_effect <= 1'h0;
        wr(8'h08, 16'h8000);
        core(1'h1, 4'h0);
        cyc(6);
        chk({28'h0, cpu_level}, 32'h7);
        wr(8'h00, 16'h0000);
        rd(8'h00, 16'h00e0);
        core(1'h0, 4'h0);
        wr(8'h08, 16'h0000);
        cyc(2);
        chk({31'h0, irq_request}, 32'h0);
        pulse(9);
        cyc(1);
        chk({19'h0, irq_request, irq_level, irq_vector}, 32'h1906);
        wr(8'h10, 16'h0000);
        core(1'h1, 4'h0);
        pulse(7);
        cyc(6);
        chk({28'h0, cpu_level}, 32'hc);
        rd(8'h04, 16'h0008);
        core(1'h0, 4'h0);
        pulse(6);
        cyc(1);
        chk({19'h0, irq_request, irq_level, irq_vector}, 32'h1e01);
        wr(8'h08, 16'h0000);
        wr(8'h04, 16'h0000);
        wr(8'h00, 16'h0000);
        wr(8'h1c, 16'h0000);
        rd(8'h04, 16'h0000);
        $display("user test done");
    endtask
    task automatic t_edge;
        wr(8'h0c, 16'h8001);
        @(posedge hclk);
        ext_irq_pin <= 4'h3;
        cyc(8);
        rd(8'h1c, 16'h0002);
        wr(8'h1c, 16'h0000);
        wr(8'h24, 16'hffff);
        rd(8'h24, 16'h7777);
        @(posedge hclk);
        ext_irq_pin <= 4'h0;
        cyc(8);
        chk({19'h0, irq_request, irq_level, irq_vector}, 32'h1708);
        @(posedge hclk);
        holdoff_in_effect <= 1'h1;
        cyc(3);
        chk({19'h0, irq_request, irq_level, irq_vector}, 32'h1708);
        @(posedge hclk);
        holdoff_in_effect <= 1'h0;
        rd(8'h1c, 16'h0001);
        wr(8'h1c, 16'h0000);
        rd(8'h1c, 16'h0000);
        $display("edge test done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        n_mismatch++;
        results;
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        t_regs;
        t_traps;
        t_user;
        t_edge;
        results;
    end
endmodule
